/* rtl/pcs_pkg.sv */
// Constants, types and command codes for the configuration and power-up block.
// Summary of operation
// - A 64-bit user signature, freely programmable, sits beside the logic array.
// - Signature read-back works whether or not the security bit is set.
// - Full image is 5892 bits; a 5828-bit image without signature is also accepted.
// - With the security bit set, read-back of array bits returns nothing useful.
// - Only a full erase clears the security bit.
// - Four serial signals (data in, data out, clock, mode) drive a programming FSM.
// - Images are shifted in serially and held in non-volatile storage.
// - Every registered output can be synchronously preloaded high or low for test.
// - Undriven serial data input reads low, keeping programming idle.
// - Floating logic inputs and tri-stated I/O pins read as one.
// - Reset clears all internal registers low within one microsecond.
// - After reset, enabled registered pins show level set by programmed polarity.
package pcs_pkg;

    // ----------------------------------------------------------------
    // array layout
    // ----------------------------------------------------------------
    localparam int ADDR_W = 13;
    localparam logic [ADDR_W-1:0] STD_IMG_BITS = 13'h16C4;  // 5828 bits
    localparam logic [ADDR_W-1:0] FULL_IMG_BITS = 13'h1704; // 5892 bits
    localparam logic [ADDR_W-1:0] SIG_BASE = 13'h16C4;
    localparam logic [ADDR_W-1:0] SIG_BITS = 13'h0040;      // 64 signature bits
    localparam logic [ADDR_W-1:0] SEC_IDX = 13'h1704;       // security cell
    localparam int CFG_BITS = 5893;
    localparam int NUM_MC = 10;
    localparam logic [ADDR_W-1:0] POL_BASE = 13'h16A0;
    localparam logic [ADDR_W-1:0] OE_BASE = 13'h16B0;

    // ----------------------------------------------------------------
    // serial commands, shifted msb first while mode is high
    // ----------------------------------------------------------------
    localparam logic [7:0] CMD_ERASE = 8'h01;
    localparam logic [7:0] CMD_PROG_FULL = 8'h02;
    localparam logic [7:0] CMD_PROG_STD = 8'h03;
    localparam logic [7:0] CMD_PROG_SIG = 8'h04;
    localparam logic [7:0] CMD_READ_ARR = 8'h05;
    localparam logic [7:0] CMD_READ_SIG = 8'h06;
    localparam logic [7:0] CMD_SECURE = 8'h07;

    // ----------------------------------------------------------------
    // timing and buffering
    // ----------------------------------------------------------------
    localparam int CLK_NS = 10;
    localparam int TPR_NS = 1000;
    localparam int PR_CYCLES = TPR_NS / CLK_NS;
    localparam logic [6:0] PR_COUNT = 7'(PR_CYCLES);
    localparam int FIFO_DEPTH = 8;
    localparam int BYTE_W = 8;
    localparam logic [3:0] BYTE_LAST = 4'h7;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_CMD = 3'b001,
        ST_LOAD = 3'b010,
        ST_READ_ARR = 3'b011,
        ST_READ_SIG = 3'b100,
        ST_ERASE = 3'b101,
        ST_SECURE = 3'b110
    } pcs_state_t;

    typedef struct packed {
        logic [3:0] nbits;
        logic [7:0] data;
    } pcs_word_t;

    localparam int WORD_W = $bits(pcs_word_t);

endpackage

/* rtl/pcs_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides.
`timescale 1ns/1ps
module pcs_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 8
) (
    input wire logic clk_i,               // clock
    input wire logic reset_i,             // sync reset, high
    input wire logic in_valid_i,          // write request
    output logic in_ready_o,              // not full
    input wire logic [WIDTH-1:0] in_data_i, // write data
    output logic out_valid_o,             // not empty
    input wire logic out_ready_i,         // read accept
    output logic [WIDTH-1:0] out_data_o   // head word
);
    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0] DEPTH_C = (PW+1)'(DEPTH);

    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [PW-1:0] wr_ptr_reg;
    logic [PW-1:0] rd_ptr_reg;
    logic [PW:0] count_reg;
    logic push;
    logic pop;

    assign in_ready_o = (count_reg != DEPTH_C);
    assign out_valid_o = (count_reg != '0);
    assign out_data_o = mem[rd_ptr_reg];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end

endmodule

/* rtl/pcs_config_loader.sv */
// Serial programming port, configuration store, security, preload and power-up reset.
`timescale 1ns/1ps
module pcs_config_loader
    import pcs_pkg::*;
(
    input wire logic clk_i,                          // logic clock, 100 MHz
    input wire logic reset_i,                        // power-up reset, sync, high
    input wire logic serial_prog_clk_i,              // serial shift clock pin
    input wire logic serial_prog_mode_i,             // mode control pin
    input wire logic serial_prog_data_in_i,          // serial data pin level
    input wire logic serial_prog_data_in_driven_i,   // data pin actively driven
    output logic serial_prog_data_out_o,             // serial read-back data
    input wire logic [NUM_MC-1:0] io_pin_i,          // i/o pin levels
    input wire logic [NUM_MC-1:0] io_float_i,        // i/o pin left floating
    input wire logic [NUM_MC-1:0] next_state_i,      // array next-state terms
    input wire logic preload_en_i,                   // force registers
    input wire logic [NUM_MC-1:0] preload_value_i,   // forced register values
    output logic [NUM_MC-1:0] io_sense_o,            // resolved, synced pin levels
    output logic [NUM_MC-1:0] reg_pin_o,             // registered output levels
    output logic [NUM_MC-1:0] reg_pin_oe_o,          // registered output enables
    output logic ready_o,                            // power-up reset complete
    output logic busy_o,                             // programming activity
    output logic secure_o,                           // security cell state
    output logic overrun_o,                          // load byte lost, fifo full
    output logic refused_o                           // protected read refused
);
    // ----------------------------------------------------------------
    // pin resolution and synchronisers
    // ----------------------------------------------------------------
    localparam int NSYNC = NUM_MC + 3;

    logic [NSYNC-1:0] raw;
    logic [NSYNC-1:0] s1_reg;
    logic [NSYNC-1:0] s2_reg;
    logic [NSYNC-1:0] s3_reg;
    logic [NSYNC-1:0] filt_reg;
    logic sdi_level;
    logic sclk_f;
    logic mode_f;
    logic sdi_f;
    logic sclk_prev_reg;
    logic mode_prev_reg;
    logic sclk_rise;
    logic mode_rise;
    logic mode_fall;

    assign sdi_level = serial_prog_data_in_driven_i & serial_prog_data_in_i;
    assign raw = {serial_prog_clk_i, serial_prog_mode_i, sdi_level,
                  io_pin_i | io_float_i};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge clk_i) begin
                if (reset_i) begin
                    s1_reg[gi] <= 1'b0;
                    s2_reg[gi] <= 1'b0;
                    s3_reg[gi] <= 1'b0;
                    filt_reg[gi] <= 1'b0;
                end else begin
                    s1_reg[gi] <= raw[gi];
                    s2_reg[gi] <= s1_reg[gi];
                    s3_reg[gi] <= s2_reg[gi];
                    if (s2_reg[gi] == s3_reg[gi]) begin
                        filt_reg[gi] <= s3_reg[gi];
                    end
                end
            end
        end
    endgenerate

    assign sclk_f = filt_reg[NSYNC-1];
    assign mode_f = filt_reg[NSYNC-2];
    assign sdi_f = filt_reg[NSYNC-3];

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            sclk_prev_reg <= 1'b0;
            mode_prev_reg <= 1'b0;
        end else begin
            sclk_prev_reg <= sclk_f;
            mode_prev_reg <= mode_f;
        end
    end

    // data is taken on filtered serial clock rises only; mode acts on its own filtered edges
    assign sclk_rise = sclk_f & ~sclk_prev_reg;
    assign mode_rise = mode_f & ~mode_prev_reg;
    assign mode_fall = ~mode_f & mode_prev_reg;

    // ----------------------------------------------------------------
    // configuration store, non-volatile so never reset
    // ----------------------------------------------------------------
    logic cfg_mem [0:CFG_BITS-1];
    logic secure_bit;

    assign secure_bit = cfg_mem[SEC_IDX];

    // ----------------------------------------------------------------
    // programming state machine
    // ----------------------------------------------------------------
    pcs_state_t state_reg;
    logic [7:0] cmd_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [ADDR_W-1:0] limit_reg;
    logic [7:0] byte_reg;
    logic [3:0] bit_cnt_reg;
    logic push_reg;
    pcs_word_t push_word_reg;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [WORD_W-1:0] fifo_out_data;
    logic wr_busy_reg;
    logic [7:0] wr_data_reg;
    logic [3:0] wr_left_reg;
    logic [ADDR_W-1:0] wr_addr_reg;
    logic [ADDR_W-1:0] wr_limit_reg;
    logic wr_go;
    logic refused_reg;
    logic overrun_reg;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_reg <= ST_IDLE;
            cmd_reg <= 8'h00;
            addr_reg <= '0;
            limit_reg <= '0;
            refused_reg <= 1'b0;
        end else if (mode_rise && state_reg != ST_ERASE) begin
            state_reg <= ST_CMD;
            cmd_reg <= 8'h00;
        end else begin
            case (state_reg)
                ST_CMD: begin
                    if (sclk_rise && mode_f) begin
                        cmd_reg <= {cmd_reg[6:0], sdi_f};
                    end else if (mode_fall) begin
                        refused_reg <= 1'b0;
                        case (cmd_reg)
                            CMD_ERASE: begin
                                state_reg <= ST_ERASE;
                                addr_reg <= '0;
                            end
                            CMD_PROG_FULL: begin
                                state_reg <= ST_LOAD;
                                addr_reg <= '0;
                                limit_reg <= FULL_IMG_BITS;
                            end
                            CMD_PROG_STD: begin
                                state_reg <= ST_LOAD;
                                addr_reg <= '0;
                                limit_reg <= STD_IMG_BITS;
                            end
                            CMD_PROG_SIG: begin
                                state_reg <= ST_LOAD;
                                addr_reg <= SIG_BASE;
                                limit_reg <= FULL_IMG_BITS;
                            end
                            CMD_READ_ARR: begin
                                state_reg <= ST_READ_ARR;
                                addr_reg <= '0;
                                refused_reg <= secure_bit;
                            end
                            CMD_READ_SIG: begin
                                state_reg <= ST_READ_SIG;
                                addr_reg <= SIG_BASE;
                            end
                            CMD_SECURE: begin
                                state_reg <= ST_SECURE;
                            end
                            default: begin
                                state_reg <= ST_IDLE;
                            end
                        endcase
                    end
                end
                ST_ERASE: begin
                    if (addr_reg == SEC_IDX) begin
                        state_reg <= ST_IDLE;
                    end else begin
                        addr_reg <= addr_reg + 1'b1;
                    end
                end
                ST_SECURE: begin
                    state_reg <= ST_IDLE;
                end
                ST_READ_ARR, ST_READ_SIG: begin
                    if (sclk_rise && !mode_f) begin
                        addr_reg <= addr_reg + 1'b1;
                    end
                end
                ST_LOAD, ST_IDLE: begin
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // serial load: bytes into the fifo, partial byte flushed on mode rise
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            byte_reg <= 8'h00;
            bit_cnt_reg <= 4'h0;
            push_reg <= 1'b0;
            push_word_reg <= '0;
        end else begin
            push_reg <= 1'b0;
            if (state_reg == ST_LOAD && sclk_rise && !mode_f) begin
                byte_reg <= {byte_reg[6:0], sdi_f};
                if (bit_cnt_reg == BYTE_LAST) begin
                    push_reg <= 1'b1;
                    push_word_reg <= '{nbits: 4'h8, data: {byte_reg[6:0], sdi_f}};
                    bit_cnt_reg <= 4'h0;
                end else begin
                    bit_cnt_reg <= bit_cnt_reg + 1'b1;
                end
            end else if (state_reg == ST_LOAD && mode_rise && bit_cnt_reg != 4'h0) begin
                push_reg <= 1'b1;
                push_word_reg <= '{nbits: bit_cnt_reg,
                                   data: 8'(byte_reg << (4'h8 - bit_cnt_reg))};
                bit_cnt_reg <= 4'h0;
            end else if (state_reg != ST_LOAD) begin
                bit_cnt_reg <= 4'h0;
            end
        end
    end

    // serial side cannot be stalled, so a full fifo loses the byte and says so
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            overrun_reg <= 1'b0;
        end else if (push_reg && !fifo_in_ready) begin
            overrun_reg <= 1'b1;
        end else if (mode_rise) begin
            overrun_reg <= 1'b0;
        end
    end

    pcs_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .in_valid_i(push_reg),
        .in_ready_o(fifo_in_ready),
        .in_data_i(push_word_reg),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(!wr_busy_reg),
        .out_data_o(fifo_out_data)
    );

    // ----------------------------------------------------------------
    // array writer: one bit per cycle, stalls the fifo while busy
    // ----------------------------------------------------------------
    assign wr_go = wr_busy_reg && wr_addr_reg < wr_limit_reg;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            wr_busy_reg <= 1'b0;
            wr_data_reg <= 8'h00;
            wr_left_reg <= 4'h0;
            wr_addr_reg <= '0;
            wr_limit_reg <= '0;
        end else begin
            if (state_reg == ST_CMD && mode_fall) begin
                wr_addr_reg <= (cmd_reg == CMD_PROG_SIG) ? SIG_BASE : '0;
                wr_limit_reg <= (cmd_reg == CMD_PROG_STD) ? STD_IMG_BITS : FULL_IMG_BITS;
            end
            if (!wr_busy_reg && fifo_out_valid) begin
                wr_busy_reg <= 1'b1;
                wr_data_reg <= fifo_out_data[7:0];
                wr_left_reg <= fifo_out_data[11:8];
            end else if (wr_busy_reg) begin
                wr_data_reg <= {wr_data_reg[6:0], 1'b0};
                wr_left_reg <= wr_left_reg - 1'b1;
                if (wr_go) begin
                    wr_addr_reg <= wr_addr_reg + 1'b1;
                end
                if (wr_left_reg == 4'h1) begin
                    wr_busy_reg <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (state_reg == ST_ERASE) begin
            cfg_mem[addr_reg] <= 1'b0;
        end else if (state_reg == ST_SECURE) begin
            cfg_mem[SEC_IDX] <= 1'b1;
        end else if (wr_go) begin
            cfg_mem[wr_addr_reg] <= wr_data_reg[7];
        end
    end

    // ----------------------------------------------------------------
    // read-back and status outputs
    // ----------------------------------------------------------------
    logic sdo_reg;
    logic busy_reg;
    logic secure_reg;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            sdo_reg <= 1'b0;
            busy_reg <= 1'b0;
            secure_reg <= 1'b0;
        end else begin
            if (state_reg == ST_READ_SIG) begin
                sdo_reg <= cfg_mem[addr_reg];
            end else if (state_reg == ST_READ_ARR && addr_reg < SIG_BASE) begin
                sdo_reg <= cfg_mem[addr_reg] & ~secure_bit;
            end else begin
                sdo_reg <= 1'b0;
            end
            busy_reg <= wr_busy_reg || fifo_out_valid || state_reg == ST_ERASE;
            secure_reg <= secure_bit;
        end
    end

    assign serial_prog_data_out_o = sdo_reg;
    assign refused_o = refused_reg;
    assign overrun_o = overrun_reg;
    assign busy_o = busy_reg;
    assign secure_o = secure_reg;

    // ----------------------------------------------------------------
    // macrocell registers, preload and power-up timing
    // ----------------------------------------------------------------
    logic [NUM_MC-1:0] mc_q_reg;
    logic [NUM_MC-1:0] pin_reg;
    logic [NUM_MC-1:0] oe_reg;
    logic [NUM_MC-1:0] pol;
    logic [NUM_MC-1:0] oe_cfg;
    logic [NUM_MC-1:0] sense_reg;
    logic [6:0] pr_cnt_reg;
    logic ready_reg;

    generate
        for (gi = 0; gi < NUM_MC; gi++) begin : g_cfg
            assign pol[gi] = cfg_mem[POL_BASE + ADDR_W'(gi)];
            assign oe_cfg[gi] = cfg_mem[OE_BASE + ADDR_W'(gi)];
        end
    endgenerate

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            mc_q_reg <= '0;
        end else if (preload_en_i) begin
            mc_q_reg <= preload_value_i;
        end else begin
            mc_q_reg <= next_state_i;
        end
    end

    // an unprogrammed polarity bit means active low, so reset pins read high
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pin_reg <= '0;
            oe_reg <= '0;
            sense_reg <= '0;
        end else begin
            pin_reg <= mc_q_reg ^ ~pol;
            oe_reg <= oe_cfg;
            sense_reg <= filt_reg[NUM_MC-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pr_cnt_reg <= 7'h00;
            ready_reg <= 1'b0;
        end else if (pr_cnt_reg == PR_COUNT - 7'h01) begin
            ready_reg <= 1'b1;
        end else begin
            pr_cnt_reg <= pr_cnt_reg + 7'h01;
        end
    end

    assign reg_pin_o = pin_reg;
    assign reg_pin_oe_o = oe_reg;
    assign io_sense_o = sense_reg;
    assign ready_o = ready_reg;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    // pin checks wait for a full erase: the array is unknown until then
    logic cfg_erased_reg;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cfg_erased_reg <= 1'b0;
        end else if (state_reg == ST_ERASE && addr_reg == SEC_IDX) begin
            cfg_erased_reg <= 1'b1;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    sequence s_cmd_end;
        state_reg == ST_CMD && mode_fall && cmd_reg == CMD_READ_SIG;
    endsequence

    sig_read_open_a: assert property (s_cmd_end |=> state_reg == ST_READ_SIG && !refused_reg)
        else $error("signature read not entered");
    arr_read_block_a: assert property (state_reg == ST_READ_ARR && secure_bit |=> !sdo_reg)
        else $error("protected array bit leaked");
    secure_hold_a: assert property ($past(secure_bit) && $past(state_reg) != ST_ERASE
        |-> secure_bit)
        else $error("security cell cleared without erase");
    preload_force_a: assert property (preload_en_i |=> mc_q_reg == $past(preload_value_i))
        else $error("preload value not forced");
    sdi_pull_a: assert property (!serial_prog_data_in_driven_i [*4] |=> !s3_reg[NSYNC-3])
        else $error("undriven data input not low");
    io_pull_a: assert property (io_float_i[0] [*5] |=> sense_reg[0])
        else $error("floating pin not high");
    reset_clear_a: assert property (disable iff (1'b0) reset_i |=> mc_q_reg == '0 && !ready_reg
        && state_reg == ST_IDLE)
        else $error("reset left register set");
    ready_time_a: assert property ($fell(reset_i) |-> ##[99:100] ready_reg)
        else $error("power-up ready late");
    pin_polarity_a: assert property (cfg_erased_reg
        |=> pin_reg == ($past(mc_q_reg) ^ ~$past(pol)))
        else $error("pin level ignores polarity");
    write_limit_a: assert property (wr_go |-> wr_addr_reg < FULL_IMG_BITS)
        else $error("write beyond image");
    cmd_shift_a: assert property (state_reg == ST_CMD && sclk_rise && mode_f && !mode_rise
        |=> cmd_reg[0] == $past(sdi_f))
        else $error("command bit not shifted");

endmodule

/* testbench/pcs_prog_model.sv */
// Programmer model driving the four-wire serial programming port.
`timescale 1ns/1ps
module pcs_prog_model (
    input wire logic clk_i, // bench clock
    input wire logic sdo_i, // read-back data
    output logic sclk_o, // shift clock
    output logic mode_o, // mode control
    output logic sdi_o, // serial data
    output logic driven_o // data pin driven
);
    initial begin
        sclk_o = 1'b0;
        mode_o = 1'b0;
        sdi_o = 1'b1;
        driven_o = 1'b0;
    end
    // clock idles low between bits; a released pin shows the inverse of its last value
    task automatic shift(input logic v);
        @(negedge clk_i);
        sdi_o = v;
        driven_o = 1'b1;
        #62.5 sclk_o = 1'b1;
        #62.5 sclk_o = 1'b0;
        sdi_o = ~v;
        driven_o = 1'b0;
        repeat (3) @(negedge clk_i);
    endtask
    task automatic cmd(input logic [7:0] c);
        @(negedge clk_i);
        mode_o = 1'b1;
        for (int i = 7; i >= 0; i--) begin
            shift(c[i]);
        end
        mode_o = 1'b0;
        repeat (10) @(negedge clk_i);
    endtask
    task automatic rd(output logic [63:0] q);
        for (int i = 0; i < 64; i++) begin
            q[i] = sdo_i;
            shift(1'b0);
        end
    endtask
endmodule

/* testbench/pcs_config_loader_tb.sv */
// Self-checking bench for the configuration loader.
`timescale 1ns/1ps
module pcs_config_loader_tb;
    import pcs_pkg::*;
    localparam logic [63:0] SIG = 64'hC3A5_0F1E_7D29_B486;
    logic clk_i, reset_i, sclk, mode, serial_prog_data_in, drv, serial_prog_data_out, pl_en, ready, busy, secure, ovr, refused;
    logic [NUM_MC-1:0] pin, flt, pl_val, sense, reg_pin, oe, ns;
    logic [63:0] q;
    int error_cnt = 0;
    int cmp_count = 0;
    pcs_prog_model i_prog (.clk_i(clk_i), .sdo_i(serial_prog_data_out), .sclk_o(sclk), .mode_o(mode),
        .sdi_o(serial_prog_data_in), .driven_o(drv));
    pcs_config_loader i_dut (.clk_i(clk_i), .reset_i(reset_i), .serial_prog_clk_i(sclk),
        .serial_prog_mode_i(mode), .serial_prog_data_in_i(serial_prog_data_in),
        .serial_prog_data_in_driven_i(drv), .serial_prog_data_out_o(serial_prog_data_out), .io_pin_i(pin),
        .io_float_i(flt), .next_state_i(ns), .preload_en_i(pl_en),
        .preload_value_i(pl_val), .io_sense_o(sense), .reg_pin_o(reg_pin),
        .reg_pin_oe_o(oe), .ready_o(ready), .busy_o(busy), .secure_o(secure),
        .overrun_o(ovr), .refused_o(refused));
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic erase();
        int n;
        n = 0;
        i_prog.cmd(8'h01);
        while (busy !== 1'b0 && n < 7000) begin
            @(negedge clk_i);
            n++;
        end
        check({busy, secure, oe}, 64'h0);
    endtask
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    initial begin
        #400000;
        error_cnt++;
        close_out();
    end
    initial begin
        {reset_i, pl_en, pin, flt, pl_val, ns} = {2'b10, 40'h0};
        repeat (3) @(negedge clk_i);
        check({reg_pin, oe, ready}, 64'h0);
        reset_i = 1'b0;
        repeat (99) @(negedge clk_i);
        check({ready, busy}, 64'h0);
        @(negedge clk_i);
        check(ready, 64'h1);
        $display("test reset done");
        erase();
        i_prog.cmd(8'h04);
        for (int i = 0; i < 64; i++) i_prog.shift(SIG[i]);
        i_prog.cmd(8'h06);
        check(ovr, 64'h0);
        i_prog.rd(q);
        check(q, SIG);
        $display("test signature done");
        i_prog.cmd(8'h07);
        check(secure, 64'h1);
        i_prog.cmd(8'h05);
        check(refused, 64'h1);
        i_prog.rd(q);
        check(q, 64'h0);
        i_prog.cmd(8'h06);
        check(refused, 64'h0);
        i_prog.rd(q);
        check(q, SIG);
        erase();
        $display("test security done");
        {flt, pl_en, pl_val} = {10'h3FF, 1'b1, 10'h2A5};
        repeat (6) @(negedge clk_i);
        check(sense, 64'h3FF);
        q = 64'(reg_pin);
        {flt, pin, pl_val} = {10'h000, 10'h2A5, 10'h15A};
        repeat (6) @(negedge clk_i);
        check(sense, 64'h2A5);
        check(q ^ 64'(reg_pin), 64'h3FF);
        check(reg_pin, 64'h2A5);
        {pl_en, ns} = {1'b0, 10'h0F0};
        repeat (3) @(negedge clk_i);
        check(reg_pin, 64'h30F);
        $display("test pins done");
        close_out();
    end
endmodule
